// *** hdl/port_phy_regs_consts.svh ***
// register offsets, field positions and management-register map for the port phy register bank
// assumes byte-wide registers on an 8-bit address and 16-bit management registers
`ifndef PORT_PHY_REGS_CONSTS_SVH
`define PORT_PHY_REGS_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADDR_P1_CTL   8'h2d
`define ADDR_P1_STAT  8'h2e
`define ADDR_P1_MODE  8'h2f
`define ADDR_P2_CTL   8'h3d
`define ADDR_P2_STAT  8'h3e
`define ADDR_P2_MODE  8'h3f
`define ADDR_P3_CTL   8'h4d
`define ADDR_P4_CTL   8'h5d

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTL_BLANK     7
`define CTL_TXOFF     6
`define CTL_RENEG     5
`define CTL_PDOWN     3
`define CTL_XAUTOOFF  2
`define CTL_STRAIGHT  1
`define CTL_MACLOOP   0

// ----------------------------------------------------------------
// combined control / mode register fields
// ----------------------------------------------------------------
`define MODE_PHYLOOP  7
`define MODE_DETACH   5
`define MODE_SOFTRST  4
`define MODE_FLINK    3
`define MODE_OPM_HI   2

`define REG_RESET     8'h00

// ----------------------------------------------------------------
// management serial register map
// ----------------------------------------------------------------
`define MII_CTRL      5'h00
`define MII_STAT      5'h01
`define MII_LPA       5'h05
`define MII_RESET     15
`define MII_LOOP      14
`define MII_PDOWN     11
`define MII_ISO       10
`define MII_RESTART   9
`define MII_ANDONE    5
`define MII_LINK      2
`define MII_LPA_PAUSE 10
`define MII_LPA_LO    5
`define MII_LPA_HI    8
`define MII_ZERO      16'h0000

`endif

// *** hdl/port_phy_regs_pkg.sv ***
// types shared by the port phy register bank
// assumes the constants header supplies all numeric values except the operating mode codes below
package port_phy_regs_pkg;

    typedef logic [7:0]  regByte_t;
    typedef logic [15:0] miiWord_t;

    // operating mode codes reported by the phy
    typedef enum logic [2:0] {
        OPM_RSVD0    = 3'h0,
        OPM_NEGOT    = 3'h1,
        OPM_10_HALF  = 3'h2,
        OPM_100_HALF = 3'h3,
        OPM_RSVD4    = 3'h4,
        OPM_10_FULL  = 3'h5,
        OPM_100_FULL = 3'h6,
        OPM_RSVD7    = 3'h7
    } opMode_e;

endpackage

// *** hdl/port_phy_control_status_regs.sv ***
// control and status registers of the two copper ports, plus mac loopback of ports 3 and 4
// assumes phy status inputs come from logic on clk_sys; indicator inputs are internal
// Overview of operation
// - indicator-blank bit 7 forces all port indicator pins high.
// - control bit 6 disables the port transmitter.
// - control bit 5 restarts negotiation and clears itself.
// - control bit 3 powers down the port phy.
// - control bit 2 turns automatic crossover off.
// - with crossover off, bit 1 forces straight wiring, else crossed.
// - port 1 bit 0 loops monitor-port frames through port 1 mac.
// - ports 3 and 4 bit 0 do the same mac loopback.
// - ports 3 and 4 control bits 7 to 1 are reserved.
// - status bit 7 shows crossover state, bit 6 negotiation complete.
// - status bit 5 shows link good.
// - status bits 4 to 0 show partner abilities.
// - port 1 combined bit 7 loops frames through port 1 pmd/pma.
// - port 2 combined bit 7 does the same on port 2.
// - combined bit 5 isolates the phy from mac side and line.
// - combined bit 4 soft-resets the phy and clears itself.
// - combined bit 3 forces the link up.
// - combined bits 2 to 0 read the operating mode.
// - power-down, phy loopback, isolate, restart, soft-reset, link, negotiation and partner bits are mirrored onto standard management registers.
// - control registers sit at 0x2d and 0x3d for ports 1 and 2, 0x4d and 0x5d for ports 3 and 4.
`timescale 1ns/10ps
`include "port_phy_regs_consts.svh"

module port_phy_control_status_regs #(
    parameter int NPHY = 2,
    parameter int NMAC = 4
) (
    input  wire logic                              clk_sys,
    input  wire logic                              rst,
    input  wire logic [7:0]                        regAddr,
    input  wire logic                              regWrEn,
    input  wire logic                              regRdEn,
    input  wire port_phy_regs_pkg::regByte_t       regWrData,
    output      port_phy_regs_pkg::regByte_t       regRdData,
    output      logic                              regRdValid,
    input  wire logic                              miiPort,
    input  wire logic [4:0]                        miiAddr,
    input  wire logic                              miiWrEn,
    input  wire logic                              miiRdEn,
    input  wire port_phy_regs_pkg::miiWord_t       miiWrData,
    output      port_phy_regs_pkg::miiWord_t       miiRdData,
    output      logic                              miiRdValid,
    input  wire logic [NPHY-1:0]                   ledAIn,
    input  wire logic [NPHY-1:0]                   ledBIn,
    input  wire logic [NPHY-1:0]                   xoverIsMdi,
    input  wire logic [NPHY-1:0]                   negotiationComplete,
    input  wire logic [NPHY-1:0]                   linkGood,
    input  wire logic [NPHY-1:0][4:0]              partnerAbility,
    input  wire port_phy_regs_pkg::opMode_e [NPHY-1:0] opMode,
    output      logic [NPHY-1:0]                   portIndicatorA,
    output      logic [NPHY-1:0]                   portIndicatorB,
    output      logic [NPHY-1:0]                   txDisable,
    output      logic [NPHY-1:0]                   renegotiate,
    output      logic [NPHY-1:0]                   powerDown,
    output      logic [NPHY-1:0]                   crossoverAutoOff,
    output      logic [NPHY-1:0]                   straightWiringForce,
    output      logic [NMAC-1:0]                   macLoopback,
    output      logic [NPHY-1:0]                   lineSideReturnPath,
    output      logic [NPHY-1:0]                   phyDetach,
    output      logic [NPHY-1:0]                   phySoftReset,
    output      logic [NPHY-1:0]                   forceLink
);

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    logic [NPHY-1:0] ctlWr;
    logic [NPHY-1:0] modeWr;
    logic [NMAC-1:0] loopWr;
    logic [NPHY-1:0] mCtlWr;

    always_comb begin
        ctlWr[0]  = regWrEn && (regAddr == `ADDR_P1_CTL);
        ctlWr[1]  = regWrEn && (regAddr == `ADDR_P2_CTL);
        modeWr[0] = regWrEn && (regAddr == `ADDR_P1_MODE);
        modeWr[1] = regWrEn && (regAddr == `ADDR_P2_MODE);
        loopWr[0] = ctlWr[0];
        loopWr[1] = ctlWr[1];
        loopWr[2] = regWrEn && (regAddr == `ADDR_P3_CTL);
        loopWr[3] = regWrEn && (regAddr == `ADDR_P4_CTL);
        mCtlWr[0] = miiWrEn && (miiAddr == `MII_CTRL) && !miiPort;
        mCtlWr[1] = miiWrEn && (miiAddr == `MII_CTRL) && miiPort;
    end

    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    // the register port wins over the management port when both write the same port
    logic [NPHY-1:0] blank_q, txOff_q, reneg_q, pDown_q, xAutoOff_q, straight_q;
    logic [NPHY-1:0] phyLoop_q, detach_q, softRst_q, fLink_q;
    logic [NMAC-1:0] macLoop_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            blank_q    <= '0;
            txOff_q    <= '0;
            pDown_q    <= '0;
            xAutoOff_q <= '0;
            straight_q <= '0;
        end else begin
            for (int p = 0; p < NPHY; p++) begin
                if (ctlWr[p]) begin
                    blank_q[p]    <= regWrData[`CTL_BLANK];
                    txOff_q[p]    <= regWrData[`CTL_TXOFF];
                    pDown_q[p]    <= regWrData[`CTL_PDOWN];
                    xAutoOff_q[p] <= regWrData[`CTL_XAUTOOFF];
                    straight_q[p] <= regWrData[`CTL_STRAIGHT];
                end else if (mCtlWr[p]) begin
                    pDown_q[p]    <= miiWrData[`MII_PDOWN];
                end
            end
        end
    end

    // only bit 0 is live on ports 3 and 4; their upper bits are never stored
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            macLoop_q <= '0;
        end else begin
            for (int m = 0; m < NMAC; m++) begin
                if (loopWr[m]) begin
                    macLoop_q[m] <= regWrData[`CTL_MACLOOP];
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            phyLoop_q <= '0;
            detach_q  <= '0;
            fLink_q   <= '0;
        end else begin
            for (int p = 0; p < NPHY; p++) begin
                if (modeWr[p]) begin
                    phyLoop_q[p] <= regWrData[`MODE_PHYLOOP];
                    detach_q[p]  <= regWrData[`MODE_DETACH];
                    fLink_q[p]   <= regWrData[`MODE_FLINK];
                end else if (mCtlWr[p]) begin
                    phyLoop_q[p] <= miiWrData[`MII_LOOP];
                    detach_q[p]  <= miiWrData[`MII_ISO];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // self-clearing commands
    // ------------------------------------------------------------
    // each bit lives one cycle as the launch pulse; a new write in that cycle wins
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reneg_q   <= '0;
            softRst_q <= '0;
        end else begin
            for (int p = 0; p < NPHY; p++) begin
                reneg_q[p] <= (ctlWr[p] && regWrData[`CTL_RENEG])
                           || (mCtlWr[p] && miiWrData[`MII_RESTART]);
                softRst_q[p] <= (modeWr[p] && regWrData[`MODE_SOFTRST])
                             || (mCtlWr[p] && miiWrData[`MII_RESET]);
            end
        end
    end

    // ------------------------------------------------------------
    // outputs to the phy and indicator pins
    // ------------------------------------------------------------
    logic [NPHY-1:0] indA_q, indB_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            indA_q <= '0;
            indB_q <= '0;
        end else begin
            for (int p = 0; p < NPHY; p++) begin
                indA_q[p] <= blank_q[p] ? 1'b1 : ledAIn[p];
                indB_q[p] <= blank_q[p] ? 1'b1 : ledBIn[p];
            end
        end
    end

    assign portIndicatorA      = indA_q;
    assign portIndicatorB      = indB_q;
    assign txDisable           = txOff_q;
    assign renegotiate         = reneg_q;
    assign powerDown           = pDown_q;
    assign crossoverAutoOff    = xAutoOff_q;
    assign straightWiringForce = straight_q;
    assign macLoopback         = macLoop_q;
    assign lineSideReturnPath  = phyLoop_q;
    assign phyDetach           = detach_q;
    assign phySoftReset        = softRst_q;
    assign forceLink           = fLink_q;

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    function automatic port_phy_regs_pkg::regByte_t ctlByte(input int p);
        ctlByte = {blank_q[p], txOff_q[p], reneg_q[p], 1'b0, pDown_q[p],
                   xAutoOff_q[p], straight_q[p], macLoop_q[p]};
    endfunction

    function automatic port_phy_regs_pkg::regByte_t statByte(input int p);
        statByte = {xoverIsMdi[p], negotiationComplete[p], linkGood[p], partnerAbility[p]};
    endfunction

    function automatic port_phy_regs_pkg::regByte_t modeByte(input int p);
        modeByte = {phyLoop_q[p], 1'b0, detach_q[p], softRst_q[p], fLink_q[p], opMode[p]};
    endfunction

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            regRdData  <= `REG_RESET;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRdEn;
            if (regRdEn) begin
                unique case (regAddr)
                    `ADDR_P1_CTL:  regRdData <= ctlByte(0);
                    `ADDR_P2_CTL:  regRdData <= ctlByte(1);
                    `ADDR_P1_STAT: regRdData <= statByte(0);
                    `ADDR_P2_STAT: regRdData <= statByte(1);
                    `ADDR_P1_MODE: regRdData <= modeByte(0);
                    `ADDR_P2_MODE: regRdData <= modeByte(1);
                    `ADDR_P3_CTL:  regRdData <= {7'h00, macLoop_q[2]};
                    `ADDR_P4_CTL:  regRdData <= {7'h00, macLoop_q[3]};
                    default:       regRdData <= `REG_RESET;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // management serial register mirror
    // ------------------------------------------------------------
    port_phy_regs_pkg::miiWord_t mRd;
    int mp;

    always_comb begin
        mp  = miiPort ? 1 : 0;
        mRd = `MII_ZERO;
        unique case (miiAddr)
            `MII_CTRL: begin
                mRd[`MII_RESET]   = softRst_q[mp];
                mRd[`MII_LOOP]    = phyLoop_q[mp];
                mRd[`MII_PDOWN]   = pDown_q[mp];
                mRd[`MII_ISO]     = detach_q[mp];
                mRd[`MII_RESTART] = reneg_q[mp];
            end
            `MII_STAT: begin
                mRd[`MII_ANDONE] = negotiationComplete[mp];
                mRd[`MII_LINK]   = linkGood[mp] | fLink_q[mp];
            end
            `MII_LPA: begin
                mRd[`MII_LPA_PAUSE]          = partnerAbility[mp][4];
                mRd[`MII_LPA_HI:`MII_LPA_LO] = partnerAbility[mp][3:0];
            end
            default: mRd = `MII_ZERO;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            miiRdData  <= `MII_ZERO;
            miiRdValid <= 1'b0;
        end else begin
            miiRdValid <= miiRdEn;
            if (miiRdEn) begin
                miiRdData <= mRd;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    AST_BLANK_HIGH: assert property (blank_q[0] |=> portIndicatorA[0] && portIndicatorB[0])
        else $error("indicator not high while blanked");
    AST_TXOFF_WR: assert property (ctlWr[0] && regWrData[`CTL_TXOFF] |=> txDisable[0])
        else $error("transmitter not disabled after write");
    AST_RENEG_ONE: assert property (
        ctlWr[0] && regWrData[`CTL_RENEG] |=> renegotiate[0]
            ##1 (!renegotiate[0] || $past(ctlWr[0]) || $past(mCtlWr[0])))
        else $error("renegotiate not a launch pulse");
    AST_PDOWN_MII: assert property (
        mCtlWr[0] && !ctlWr[0] && miiWrData[`MII_PDOWN] |=> powerDown[0])
        else $error("management write did not power down");
    AST_P3_RSVD: assert property (
        regRdEn && regAddr == `ADDR_P3_CTL |=> regRdValid && regRdData[7:1] == 7'h00)
        else $error("reserved bits of port 3 read nonzero");
    AST_STAT_READ: assert property (
        regRdEn && regAddr == `ADDR_P1_STAT |=> regRdData[5] == $past(linkGood[0]))
        else $error("link status read wrong");
    AST_MODE_READ: assert property (
        regRdEn && regAddr == `ADDR_P2_MODE |=> regRdData[2:0] == $past(opMode[1]))
        else $error("operating mode read wrong");
    AST_SOFTRST_SC: assert property (
        softRst_q[1] && !modeWr[1] && !mCtlWr[1] |=> !phySoftReset[1])
        else $error("soft reset did not clear");
    AST_LOOP3: assert property (loopWr[2] |=> macLoopback[2] == $past(regWrData[0]))
        else $error("port 3 mac loopback not stored");

    // after the indicator checks, stored control fields must match the byte written one cycle before; status and management checks follow
    AST_BLANK_P2: assert property (
        blank_q[1] |=> portIndicatorA[1] && portIndicatorB[1])
        else $error("port 2 indicator not high while blanked");
    AST_UNBLANK: assert property (
        !blank_q[0] |=> portIndicatorA[0] == $past(ledAIn[0]))
        else $error("indicator does not follow its source");
    AST_PDOWN_WR: assert property (
        ctlWr[0] |=> powerDown[0] == $past(regWrData[`CTL_PDOWN]))
        else $error("power down not stored");
    AST_XOVER_WR: assert property (
        ctlWr[0] |=> crossoverAutoOff[0] == $past(regWrData[`CTL_XAUTOOFF])
            && straightWiringForce[0] == $past(regWrData[`CTL_STRAIGHT]))
        else $error("crossover control not stored");
    AST_LOOP1: assert property (
        ctlWr[0] |=> macLoopback[0] == $past(regWrData[`CTL_MACLOOP]))
        else $error("port 1 mac loopback not stored");
    AST_PHYLOOP_P2: assert property (
        modeWr[1] |=> lineSideReturnPath[1] == $past(regWrData[`MODE_PHYLOOP]))
        else $error("port 2 line_side_return_path not stored");
    AST_DETACH_FLINK: assert property (
        modeWr[0] |=> phyDetach[0] == $past(regWrData[`MODE_DETACH])
            && forceLink[0] == $past(regWrData[`MODE_FLINK]))
        else $error("isolate or force link not stored");
    AST_STAT_XOVER: assert property (
        regRdEn && regAddr == `ADDR_P1_STAT |=> regRdData[7] == $past(xoverIsMdi[0])
            && regRdData[6] == $past(negotiationComplete[0]))
        else $error("crossover or negotiation status read wrong");
    AST_RENEG_MII: assert property (
        mCtlWr[1] && miiWrData[`MII_RESTART] |=> renegotiate[1])
        else $error("management restart did not pulse");
    AST_MII_LINK: assert property (
        miiRdEn && !miiPort && miiAddr == `MII_STAT
            |=> miiRdData[`MII_LINK] == ($past(linkGood[0]) || $past(forceLink[0])))
        else $error("management link bit wrong");
    AST_MII_IGNORE: assert property (
        miiWrEn && !regWrEn && miiAddr != `MII_CTRL |=> $stable(powerDown))
        else $error("management write to a status word changed a control");

    COV_RENEG: cover property (ctlWr[0] && regWrData[`CTL_RENEG] ##1 renegotiate[0]);
    COV_BLANK: cover property (ctlWr[1] && regWrData[`CTL_BLANK] ##2 portIndicatorA[1]);
    COV_MII_READ: cover property (miiRdEn && miiAddr == `MII_STAT ##1 miiRdValid);
    COV_SOFTRST_MII: cover property (mCtlWr[1] && miiWrData[`MII_RESET] ##1 phySoftReset[1]);

endmodule // port_phy_control_status_regs

// *** tb/phy_status_model.sv ***
// behavioural model of the two copper phys that feed status into the register bank
// assumes it shares clk_sys and rst with the design; modeSel is set by the bench
`timescale 1ns/10ps

module phy_status_model (
    input  wire logic                             clk_sys,
    input  wire logic                             rst,
    input  wire logic [1:0]                       renegotiate,
    input  wire logic [1:0]                       phySoftReset,
    input  wire logic [1:0]                       crossoverAutoOff,
    input  wire logic [1:0]                       straightWiringForce,
    input  wire port_phy_regs_pkg::opMode_e [1:0] modeSel,
    output      logic [1:0]                       xoverIsMdi,
    output      logic [1:0]                       negotiationComplete,
    output      logic [1:0]                       linkGood,
    output      port_phy_regs_pkg::opMode_e [1:0] opMode
);
    // ----------------------------------------------------------------
    // negotiation timer
    // ----------------------------------------------------------------
    // negotiation takes a few cycles so a read can catch the negotiating mode
    logic [1:0][2:0] settleCnt_q;

    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < 2; i++) begin
            if (rst || renegotiate[i] || phySoftReset[i]) begin
                settleCnt_q[i] <= 3'h4;
            end else if (settleCnt_q[i] != 3'h0) begin
                settleCnt_q[i] <= settleCnt_q[i] - 3'h1;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            negotiationComplete[i] = (settleCnt_q[i] == 3'h0);
            linkGood[i] = negotiationComplete[i];
            opMode[i] = negotiationComplete[i] ? modeSel[i] : port_phy_regs_pkg::OPM_NEGOT;
            // auto crossover is taken to settle on crossed wiring
            xoverIsMdi[i] = crossoverAutoOff[i] & straightWiringForce[i];
        end
    end
endmodule // phy_status_model

// *** tb/port_phy_control_status_regs_bench.sv ***
// self-checking bench for the port phy register bank
// assumes the phy status model and the constants header are on the compile path
`timescale 1ns/10ps
`include "port_phy_regs_consts.svh"

module port_phy_control_status_regs_bench;
    logic                             clk_sys, rst, regWrEn, regRdEn, regRdValid;
    logic                             miiPort, miiWrEn, miiRdEn, miiRdValid;
    logic [7:0]                       regAddr, regWrData, regRdData;
    logic [4:0]                       miiAddr;
    logic [15:0]                      miiWrData, miiRdData;
    logic [1:0]                       ledAIn, ledBIn, xoverIsMdi, negotiationComplete, linkGood;
    logic [1:0]                       portIndicatorA, portIndicatorB, txDisable, renegotiate;
    logic [1:0]                       powerDown, crossoverAutoOff, straightWiringForce;
    logic [1:0]                       lineSideReturnPath, phyDetach, phySoftReset, forceLink;
    logic [1:0][4:0]                  partnerAbility;
    logic [3:0]                       macLoopback;
    port_phy_regs_pkg::opMode_e [1:0] opMode, modeSel;
    int                               errCount, totalChecks;

    port_phy_control_status_regs dut_u (.clk_sys, .rst, .regAddr, .regWrEn, .regRdEn,
        .regWrData, .regRdData, .regRdValid, .miiPort, .miiAddr, .miiWrEn, .miiRdEn,
        .miiWrData, .miiRdData, .miiRdValid, .ledAIn, .ledBIn, .xoverIsMdi,
        .negotiationComplete, .linkGood, .partnerAbility, .opMode, .portIndicatorA,
        .portIndicatorB, .txDisable, .renegotiate, .powerDown, .crossoverAutoOff,
        .straightWiringForce, .macLoopback, .lineSideReturnPath, .phyDetach,
        .phySoftReset, .forceLink);

    phy_status_model phy_u (.clk_sys, .rst, .renegotiate, .phySoftReset, .crossoverAutoOff,
        .straightWiringForce, .modeSel, .xoverIsMdi, .negotiationComplete, .linkGood, .opMode);

    // ----------------------------------------------------------------
    // clock, checks and bus tasks
    // ----------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        totalChecks++;
        if (got !== exp) begin
            errCount++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk_sys);
        regWrEn <= 1'b0;
        #1;
    endtask

    // read data is compared in the cycle its valid pulse stands
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk_sys);
        regRdEn <= 1'b0;
        #1;
        chk({11'h000, regRdValid, regRdData}, {11'h001, exp});
    endtask

    task automatic mwr(input logic p, input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        miiPort <= p;
        miiAddr <= a;
        miiWrData <= d;
        miiWrEn <= 1'b1;
        @(posedge clk_sys);
        miiWrEn <= 1'b0;
        #1;
    endtask

    task automatic mrd(input logic p, input logic [4:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        miiPort <= p;
        miiAddr <= a;
        miiRdEn <= 1'b1;
        @(posedge clk_sys);
        miiRdEn <= 1'b0;
        #1;
        chk({3'h0, miiRdValid, miiRdData}, {3'h1, exp});
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        {rst, regWrEn, regRdEn, miiWrEn, miiRdEn, miiPort} = 6'h21;
        {regAddr, regWrData, miiAddr, miiWrData} = 37'h0;
        {ledAIn, ledBIn} = 4'h4;
        partnerAbility = {5'h0a, 5'h15};
        modeSel = {port_phy_regs_pkg::OPM_10_HALF, port_phy_regs_pkg::OPM_100_FULL};
        errCount = 0;
        totalChecks = 0;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        idle(1);
        chk({txDisable, powerDown, macLoopback, phyDetach, forceLink}, 20'h0);
        rd(`ADDR_P1_CTL, 8'h00);
        rd(`ADDR_P4_CTL, 8'h00);
        rd(8'h10, 8'h00);
        idle(4);
        rd(`ADDR_P1_STAT, 8'h75);
        rd(`ADDR_P2_STAT, 8'h6a);
        rd(`ADDR_P1_MODE, 8'h06);
        wr(`ADDR_P1_CTL, 8'hcf);
        idle(1);
        chk({portIndicatorA, portIndicatorB}, 20'h5);
        chk({txDisable, powerDown, crossoverAutoOff, straightWiringForce}, 20'h55);
        chk(macLoopback, 20'h1);
        rd(`ADDR_P1_CTL, 8'hcf);
        rd(`ADDR_P1_STAT, 8'hf5);
        wr(`ADDR_P1_CTL, 8'h4f);
        idle(1);
        chk({portIndicatorA, portIndicatorB}, 20'h4);
        wr(`ADDR_P1_CTL, 8'h20);
        chk(renegotiate, 20'h1);
        idle(1);
        chk(renegotiate, 20'h0);
        rd(`ADDR_P1_MODE, 8'h01);
        rd(`ADDR_P1_CTL, 8'h00);
        wr(`ADDR_P3_CTL, 8'hff);
        wr(`ADDR_P4_CTL, 8'h01);
        chk(macLoopback, 20'hc);
        rd(`ADDR_P3_CTL, 8'h01);
        wr(`ADDR_P1_MODE, 8'hb8);
        chk(phySoftReset, 20'h1);
        idle(1);
        chk({phySoftReset, lineSideReturnPath, phyDetach, forceLink}, 20'h15);
        idle(4);
        rd(`ADDR_P1_MODE, 8'hae);
        wr(`ADDR_P2_MODE, 8'h80);
        chk(lineSideReturnPath, 20'h3);
        for (int k = 0; k < 8; k++) begin
            @(posedge clk_sys);
            modeSel[1] <= port_phy_regs_pkg::opMode_e'(k);
            rd(`ADDR_P2_MODE, 8'h80 | 8'(k));
        end
        mrd(1'b0, `MII_CTRL, 16'h4400);
        mrd(1'b0, `MII_STAT, 16'h0024);
        mrd(1'b0, `MII_LPA, 16'h04a0);
        mwr(1'b0, `MII_CTRL, 16'h0800);
        chk({powerDown, lineSideReturnPath, phyDetach}, 20'h18);
        rd(`ADDR_P1_CTL, 8'h08);
        mwr(1'b0, `MII_STAT, 16'hffff);
        chk({powerDown, lineSideReturnPath, phyDetach}, 20'h18);
        wr(`ADDR_P2_CTL, 8'hc0);
        idle(1);
        chk({portIndicatorA, portIndicatorB, txDisable}, 20'h3a);
        rd(`ADDR_P2_CTL, 8'hc0);
        mwr(1'b1, `MII_CTRL, 16'h8200);
        chk({renegotiate, phySoftReset, lineSideReturnPath}, 20'h28);
        mrd(1'b1, `MII_CTRL, 16'h0000);
        end_sim;
    end

    // the sequence needs about a hundred cycles, so this only trips on a hang
    initial begin
        repeat (3000) @(posedge clk_sys);
        errCount++;
        end_sim;
    end
endmodule // port_phy_control_status_regs_bench
